// ===== core/fifo_flag_params.svh
// Constants for the FIFO status-flag decoder: register map, defaults, depth.
// Included by the decoder and its package users; definitions only.
`ifndef FIFO_FLAG_PARAMS_SVH
`define FIFO_FLAG_PARAMS_SVH

// Array depth of the smallest wide-bus configuration
`define SFD_DEPTH 512

// APB register byte offsets
`define SFD_REG_EMPTY_OFS 12'h000
`define SFD_REG_FULL_OFS 12'h004
`define SFD_REG_STATUS 12'h008
`define SFD_REG_COUNT 12'h00c
`define SFD_REG_IRQ_STAT 12'h010
`define SFD_REG_IRQ_MASK 12'h014
`define SFD_ADDR_W 12

// Status register field positions
`define SFD_ST_FULL 0
`define SFD_ST_ALMOST_FULL 1
`define SFD_ST_HALF_FULL 2
`define SFD_ST_ALMOST_EMPTY 3
`define SFD_ST_EMPTY 4
`define SFD_ST_SHOW_AHEAD 5
`define SFD_ST_SERIAL 6
`define SFD_ST_BOTH_NINE 7

// Interrupt status bits
`define SFD_IRQ_W 4
`define SFD_IRQ_FULL 0
`define SFD_IRQ_EMPTY 1
`define SFD_IRQ_WR_REFUSED 2
`define SFD_IRQ_RD_REFUSED 3

// Default offsets, indexed by {load select, pick0, pick1}
`define SFD_DEF_OFS_000 127
`define SFD_DEF_OFS_001 511
`define SFD_DEF_OFS_010 255
`define SFD_DEF_OFS_011 63
`define SFD_DEF_OFS_100 31
`define SFD_DEF_OFS_101 15
`define SFD_DEF_OFS_110 7
`define SFD_DEF_OFS_111 3

// Flag pin levels while rstn is low (standard mode, empty)
`define SFD_RST_FULL 1'b1
`define SFD_RST_ALMOST_FULL 1'b1
`define SFD_RST_HALF_FULL 1'b1
`define SFD_RST_ALMOST_EMPTY 1'b0
`define SFD_RST_EMPTY 1'b0

`endif

// ===== core/fifo_flag_pkg.sv
// Types shared by the FIFO status-flag decoder.
// Constants live in fifo_flag_params.svh.
package fifo_flag_pkg;

    typedef enum logic
    {
        MODE_STANDARD,
        MODE_SHOW_AHEAD
    } fifoMode_t;

    typedef enum logic
    {
        LOAD_PARALLEL,
        LOAD_SERIAL
    } loadMode_t;

endpackage

// ===== core/sync_bank.sv
// Bank of two-flop synchronisers for asynchronous pins.
// Assumes one clock; clkEn freezes the bank like every other state.
`timescale 1ns/1ps
module sync_bank
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)(
    input wire logic sys_clk, // System clock
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic clkEn, // State advances only while high
    input wire logic [WIDTH-1:0] asyncIn, // Raw pin levels
    output logic [WIDTH-1:0] syncOut // Synchronised levels
);

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stage1_ff <= RST_VAL;
            stage2_ff <= RST_VAL;
        end
        else if (clkEn)
        begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
        end
    end

    assign syncOut = stage2_ff;

endmodule

// ===== core/fifo_status_flag_decode.sv
// FIFO status-flag decoder: word counter, offset registers, flag pins, APB slave.
// Assumes write/read strobes come from logic on sys_clk; straps and master reset are pins.
// Contract
// [RULE1] Standard mode: 0 words gives empty and almost-empty low, 1..n empty high, above n almost-empty high.
// [RULE2] Standard mode: half-full low above half depth, almost-full low from depth-m, full low only at depth.
// [RULE3] Show-ahead: 0 words output-ready high, 1..n+1 output-ready low, from n+2 almost-empty high.
// [RULE4] Show-ahead: half-full low from half depth+2, almost-full low from depth+1-m, input-ready high at depth+1.
// [RULE5] Show-ahead counts the output register word, so capacity is depth plus one.
// [RULE6] Empty offset sets only the almost-empty threshold; full offset sets only the almost-full threshold.
// [RULE7] Master reset selecting serial loading also loads the default offset pair picked by the two straps.
// [RULE8] Master reset selecting parallel loading also loads the default offset pair picked by the two straps.
// [RULE9] With both widths nine bits each offset uses one more bit than the wide-bus case.
// [RULE10] In any other width mix each offset uses the narrower width.
// [RULE11] Offset bits above the used width are ignored on load and read back as zero.
// [RULE12] On the largest part with mixed nine/eighteen widths the far side uses 4 cycles per offset transfer.
// [RULE13] With both widths nine bits the far side uses 6 cycles to transfer the full offset set.
// [RULE14] The far side holds load select high for serial or low for parallel during master reset.
// [RULE15] The far side keeps programmed offsets between 0 and capacity minus one.
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "fifo_flag_params.svh"
module fifo_status_flag_decode
    import fifo_flag_pkg::*;
#(
    parameter int DEPTH = `SFD_DEPTH,
    parameter int OFS_W = $clog2(DEPTH) + 1,
    parameter int CNT_W = $clog2(2 * DEPTH + 2)
)(
    input wire logic sys_clk, // System clock, 100 MHz
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic clkEn, // Freezes all state while low
    input wire logic [31:0] paddr, // APB address
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction, high for write
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic wrStrobe, // Write request, one word per cycle
    input wire logic rdStrobe, // Read request, one word per cycle
    input wire logic masterResetN, // Master reset pin, active low
    input wire logic loadSelect, // Strap: high serial, low parallel
    input wire logic defaultOffsetPick0, // Strap: default offset pick bit 0
    input wire logic defaultOffsetPick1, // Strap: default offset pick bit 1
    input wire logic showAheadMode, // Strap: high selects show-ahead
    input wire logic inputWidth, // Strap: high eighteen bits, low nine
    input wire logic outputWidth, // Strap: high eighteen bits, low nine
    output logic fullFlag, // Full (standard, low active) or input-ready
    output logic almostFullFlag, // Almost full, low active
    output logic halfFullFlag, // Half full, low active
    output logic almostEmptyFlag, // Almost empty, low while nearly empty
    output logic emptyFlag, // Empty (standard, low active) or output-ready
    output logic irq // Level interrupt
);

    localparam int HALF_STD = DEPTH / 2 + 1;

    function automatic logic [OFS_W-1:0] defaultOffset(input logic ldSel, input logic p0, input logic p1);
        logic [2:0] sel;
        sel = {ldSel, p0, p1};
        case (sel)
            3'b000: defaultOffset = OFS_W'(`SFD_DEF_OFS_000);
            3'b001: defaultOffset = OFS_W'(`SFD_DEF_OFS_001);
            3'b010: defaultOffset = OFS_W'(`SFD_DEF_OFS_010);
            3'b011: defaultOffset = OFS_W'(`SFD_DEF_OFS_011);
            3'b100: defaultOffset = OFS_W'(`SFD_DEF_OFS_100);
            3'b101: defaultOffset = OFS_W'(`SFD_DEF_OFS_101);
            3'b110: defaultOffset = OFS_W'(`SFD_DEF_OFS_110);
            default: defaultOffset = OFS_W'(`SFD_DEF_OFS_111);
        endcase
    endfunction

    function automatic logic regHit(input logic [31:0] addr, input logic [`SFD_ADDR_W-1:0] offset);
        regHit = (addr[31:`SFD_ADDR_W] == '0) && (addr[`SFD_ADDR_W-1:0] == offset);
    endfunction

    // Pin synchronisers; master reset idles inactive
    logic [6:0] pinSync;
    sync_bank #(
        .WIDTH(7),
        .RST_VAL(7'h01)
    ) u_pins (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .clkEn(clkEn),
        .asyncIn({outputWidth, inputWidth, showAheadMode, defaultOffsetPick1,
                  defaultOffsetPick0, loadSelect, masterResetN}),
        .syncOut(pinSync)
    );

    wire mrActive = ~pinSync[0];
    wire sLoadSel = pinSync[1];
    wire sPick0 = pinSync[2];
    wire sPick1 = pinSync[3];
    wire sShowAhead = pinSync[4];
    wire sBothNine = ~pinSync[5] & ~pinSync[6];

    fifoMode_t mode_ff;
    loadMode_t loadMode_ff;
    logic bothNine_ff;
    logic [OFS_W-1:0] emptyOfs_ff;
    logic [OFS_W-1:0] fullOfs_ff;
    logic [CNT_W-1:0] count_ff;
    logic [`SFD_IRQ_W-1:0] irqStat_ff;
    logic [`SFD_IRQ_W-1:0] irqMask_ff;
    logic fullFlag_ff;
    logic almostFullFlag_ff;
    logic halfFullFlag_ff;
    logic almostEmptyFlag_ff;
    logic emptyFlag_ff;
    logic irq_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    // Mode straps are caught only while master reset is held
    fifoMode_t nxt_mode;
    loadMode_t nxt_loadMode;
    logic nxt_bothNine;
    assign nxt_mode = mrActive ? (sShowAhead ? MODE_SHOW_AHEAD : MODE_STANDARD) : mode_ff;
    assign nxt_loadMode = mrActive ? (sLoadSel ? LOAD_SERIAL : LOAD_PARALLEL) : loadMode_ff; // RULE14
    assign nxt_bothNine = mrActive ? sBothNine : bothNine_ff;

    wire isShowAhead = (mode_ff == MODE_SHOW_AHEAD);
    wire nxtShowAhead = (nxt_mode == MODE_SHOW_AHEAD);

    // Used offset width follows the bus-width mix
    wire [OFS_W-1:0] ofsMask = bothNine_ff ? {OFS_W{1'b1}} : {1'b0, {(OFS_W-1){1'b1}}}; // RULE9 RULE10
    wire [OFS_W-1:0] dfltOffset = defaultOffset(sLoadSel, sPick0, sPick1);

    // Capacity: doubled array with both widths at nine, plus output register in show-ahead
    wire [CNT_W-1:0] baseDepth = bothNine_ff ? CNT_W'(2 * DEPTH) : CNT_W'(DEPTH); // RULE9
    wire [CNT_W-1:0] capacity = baseDepth + CNT_W'(isShowAhead); // RULE5
    wire [CNT_W-1:0] nxtBaseDepth = nxt_bothNine ? CNT_W'(2 * DEPTH) : CNT_W'(DEPTH);
    wire [CNT_W-1:0] nxtCapacity = nxtBaseDepth + CNT_W'(nxtShowAhead); // RULE5

    wire isFull = (count_ff == capacity);
    wire isEmpty = (count_ff == '0);
    wire doWr = wrStrobe & ~isFull;
    wire doRd = rdStrobe & ~isEmpty;
    wire [CNT_W-1:0] nxt_count = mrActive ? '0 : count_ff + CNT_W'(doWr) - CNT_W'(doRd);

    // APB decode
    wire apbSetup = psel & ~penable;
    wire apbCommit = psel & penable & pready_ff;
    wire hitEmptyOfs = regHit(paddr, `SFD_REG_EMPTY_OFS);
    wire hitFullOfs = regHit(paddr, `SFD_REG_FULL_OFS);
    wire hitStatus = regHit(paddr, `SFD_REG_STATUS);
    wire hitCount = regHit(paddr, `SFD_REG_COUNT);
    wire hitIrqStat = regHit(paddr, `SFD_REG_IRQ_STAT);
    wire hitIrqMask = regHit(paddr, `SFD_REG_IRQ_MASK);
    wire anyHit = hitEmptyOfs | hitFullOfs | hitStatus | hitCount | hitIrqStat | hitIrqMask;
    wire wrCommit = apbCommit & pwrite & anyHit;

    // Master reset wins over a software load in the same cycle
    logic [OFS_W-1:0] nxt_emptyOfs;
    logic [OFS_W-1:0] nxt_fullOfs;
    assign nxt_emptyOfs = mrActive ? dfltOffset :                        // RULE7 RULE8
                          (wrCommit & hitEmptyOfs) ? (pwdata[OFS_W-1:0] & ofsMask) : emptyOfs_ff; // RULE11
    assign nxt_fullOfs = mrActive ? dfltOffset :                         // RULE7 RULE8
                         (wrCommit & hitFullOfs) ? (pwdata[OFS_W-1:0] & ofsMask) : fullOfs_ff; // RULE11

    // Thresholds; offsets beyond capacity-1 would wrap the almost-full limit
    wire [CNT_W-1:0] aeLimit = CNT_W'(nxt_emptyOfs) + CNT_W'(nxtShowAhead); // RULE6 RULE3
    wire [CNT_W-1:0] hfLimit = (nxtBaseDepth >> 1) + CNT_W'(nxtShowAhead); // RULE2 RULE4
    wire [CNT_W-1:0] afLimit = nxtCapacity - CNT_W'(nxt_fullOfs); // RULE6 RULE15

    wire nxt_almostEmpty = (nxt_count > aeLimit); // RULE1 RULE3
    wire nxt_halfFull = ~(nxt_count > hfLimit); // RULE2 RULE4
    wire nxt_almostFull = ~(nxt_count >= afLimit); // RULE2 RULE4
    wire nxt_fullPin = nxtShowAhead ? (nxt_count == nxtCapacity) : (nxt_count != nxtCapacity); // RULE2 RULE4
    wire nxt_emptyPin = nxtShowAhead ? (nxt_count == '0) : (nxt_count != '0); // RULE1 RULE3

    // Interrupt events: set beats a same-cycle write-one clear
    wire [`SFD_IRQ_W-1:0] events = {rdStrobe & isEmpty & ~mrActive,
                                    wrStrobe & isFull & ~mrActive,
                                    ~mrActive & (nxt_count == '0) & ~isEmpty,
                                    ~mrActive & (nxt_count == capacity) & ~isFull};
    wire [`SFD_IRQ_W-1:0] irqClear = (wrCommit & hitIrqStat) ? pwdata[`SFD_IRQ_W-1:0] : '0;
    wire [`SFD_IRQ_W-1:0] nxt_irqStat = (irqStat_ff & ~irqClear) | events;
    wire [`SFD_IRQ_W-1:0] nxt_irqMask = (wrCommit & hitIrqMask) ? pwdata[`SFD_IRQ_W-1:0] : irqMask_ff;

    wire [7:0] statusWord = {bothNine_ff, loadMode_ff == LOAD_SERIAL, isShowAhead,
                             emptyFlag_ff, almostEmptyFlag_ff, halfFullFlag_ff, almostFullFlag_ff, fullFlag_ff};
    wire [31:0] readMux = hitEmptyOfs ? 32'(emptyOfs_ff & ofsMask) :   // RULE11
                          hitFullOfs ? 32'(fullOfs_ff & ofsMask) :     // RULE11
                          hitStatus ? {24'h000000, statusWord} :
                          hitCount ? 32'(count_ff) :
                          hitIrqStat ? 32'(irqStat_ff) :
                          hitIrqMask ? 32'(irqMask_ff) : 32'h00000000;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_ff <= MODE_STANDARD;
            loadMode_ff <= LOAD_PARALLEL;
            bothNine_ff <= 1'b0;
            emptyOfs_ff <= OFS_W'(`SFD_DEF_OFS_000);
            fullOfs_ff <= OFS_W'(`SFD_DEF_OFS_000);
            count_ff <= '0;
        end
        else if (clkEn)
        begin
            mode_ff <= nxt_mode;
            loadMode_ff <= nxt_loadMode;
            bothNine_ff <= nxt_bothNine;
            emptyOfs_ff <= nxt_emptyOfs;
            fullOfs_ff <= nxt_fullOfs;
            count_ff <= nxt_count;
        end
    end

    // Flags decode next count so they line up with count_ff
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fullFlag_ff <= `SFD_RST_FULL;
            almostFullFlag_ff <= `SFD_RST_ALMOST_FULL;
            halfFullFlag_ff <= `SFD_RST_HALF_FULL;
            almostEmptyFlag_ff <= `SFD_RST_ALMOST_EMPTY;
            emptyFlag_ff <= `SFD_RST_EMPTY;
        end
        else if (clkEn)
        begin
            fullFlag_ff <= nxt_fullPin;
            almostFullFlag_ff <= nxt_almostFull;
            halfFullFlag_ff <= nxt_halfFull;
            almostEmptyFlag_ff <= nxt_almostEmpty;
            emptyFlag_ff <= nxt_emptyPin;
        end
    end

    // Zero-wait APB: answer registered in setup, shown in access
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irqStat_ff <= '0;
            irqMask_ff <= '0;
            irq_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else if (clkEn)
        begin
            irqStat_ff <= nxt_irqStat;
            irqMask_ff <= nxt_irqMask;
            irq_ff <= |(nxt_irqStat & nxt_irqMask);
            prdata_ff <= (apbSetup & ~pwrite) ? readMux : 32'h00000000;
            pready_ff <= apbSetup;
            pslverr_ff <= apbSetup & ~anyHit;
        end
    end

    assign fullFlag = fullFlag_ff;
    assign almostFullFlag = almostFullFlag_ff;
    assign halfFullFlag = halfFullFlag_ff;
    assign almostEmptyFlag = almostEmptyFlag_ff;
    assign emptyFlag = emptyFlag_ff;
    assign irq = irq_ff;
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence mrLoad;
        mrActive && clkEn;
    endsequence

    sequence writeWhileFull;
        isFull && wrStrobe && !rdStrobe && !mrActive && clkEn;
    endsequence

    emptyStd_a: assert property (!isShowAhead |-> (emptyFlag == (count_ff != '0))) // RULE1
        else $error("empty flag disagrees with word count");

    almostEmpty_a: assert property (almostEmptyFlag == (count_ff > (CNT_W'(emptyOfs_ff) + CNT_W'(isShowAhead)))) // RULE6
        else $error("almost-empty flag disagrees with empty offset");

    halfFullStd_a: assert property (!isShowAhead && !bothNine_ff |-> (halfFullFlag == (count_ff < CNT_W'(HALF_STD)))) // RULE2
        else $error("half-full flag wrong in standard mode");

    fullStd_a: assert property (!isShowAhead |-> (fullFlag == (count_ff != baseDepth))) // RULE2
        else $error("full flag wrong in standard mode");

    inputReady_a: assert property (isShowAhead && !bothNine_ff |-> (fullFlag == (count_ff == CNT_W'(DEPTH + 1)))) // RULE4
        else $error("input-ready wrong in show-ahead mode");

    outputReady_a: assert property (isShowAhead |-> (emptyFlag == (count_ff == '0) && !(count_ff == '0 && almostEmptyFlag))) // RULE3
        else $error("output-ready wrong in show-ahead mode");

    almostFull_a: assert property (almostFullFlag == (count_ff < (capacity - CNT_W'(fullOfs_ff)))) // RULE6
        else $error("almost-full flag disagrees with full offset");

    capacity_bound_a: assert property (count_ff <= capacity) // RULE5
        else $error("word count above capacity");

    default_load_a: assert property (mrLoad |=> (emptyOfs_ff == $past(dfltOffset)) && (fullOfs_ff == emptyOfs_ff)) // RULE7
        else $error("default offsets not loaded at master reset");

    offset_mask_a: assert property (!bothNine_ff && !mrActive |-> !emptyOfs_ff[OFS_W-1] && !fullOfs_ff[OFS_W-1]) // RULE11
        else $error("unused offset bit set");

    refused_write_a: assert property (writeWhileFull |=> irqStat_ff[`SFD_IRQ_WR_REFUSED] && $stable(count_ff) [*1]) // RULE2
        else $error("write while full not refused and flagged");

endmodule

// ===== testbench/fifo_traffic_model.sv
// Writing and reading logic that stands beside the flag decoder.
// Assumes the decoder samples the strobes on sys_clk; one word per strobe cycle.
`timescale 1ns/1ps
module fifo_traffic_model
(
    input wire logic sys_clk, // System clock
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic go, // Start a burst, one cycle
    input wire logic dirWr, // High writes, low reads
    input wire logic [11:0] len, // Words in the burst
    output logic wrStrobe, // Write request
    output logic rdStrobe, // Read request
    output logic busy // Burst in flight
);
    logic [11:0] left_ff;

    assign busy = wrStrobe | rdStrobe;

    // Strobes stay up for exactly len edges, back to back
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            left_ff <= 12'h000;
            wrStrobe <= 1'b0;
            rdStrobe <= 1'b0;
        end
        else if (go && len != 12'h000)
        begin
            left_ff <= len - 12'h001;
            wrStrobe <= dirWr;
            rdStrobe <= !dirWr;
        end
        else if (left_ff != 12'h000)
            left_ff <= left_ff - 12'h001;
        else
        begin
            wrStrobe <= 1'b0;
            rdStrobe <= 1'b0;
        end
    end
endmodule

// ===== testbench/fifo_status_flag_decode_test.sv
// Self-checking bench for the FIFO status-flag decoder.
// Assumes the traffic model drives the strobes and APB reaches the registers.
`timescale 1ns/1ps
`include "fifo_flag_params.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin nErrors++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module fifo_status_flag_decode_test;
    import fifo_flag_pkg::*;
    logic sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
    logic wrStrobe, rdStrobe, busy, go = 0, dirWr = 0, err, irq;
    logic [11:0] len = 0;
    logic masterResetN = 1, loadSelect = 0, pick0 = 0, pick1 = 0, showAhead = 0, inW = 1, outW = 1;
    logic clkEn = 1;
    logic fullFlag, almostFullFlag, halfFullFlag, almostEmptyFlag, emptyFlag;
    int nErrors = 0, checked = 0, cycles = 0, cnt = 0;
    int defs[8] = '{127, 511, 255, 63, 31, 15, 7, 3};

    always #5 sys_clk = ~sys_clk;

    fifo_traffic_model partner (.sys_clk(sys_clk), .rstn(rstn), .go(go), .dirWr(dirWr), .len(len),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .busy(busy));

    fifo_status_flag_decode dut (.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .masterResetN(masterResetN),
        .loadSelect(loadSelect), .defaultOffsetPick0(pick0), .defaultOffsetPick1(pick1),
        .showAheadMode(showAhead), .inputWidth(inW), .outputWidth(outW), .fullFlag(fullFlag),
        .almostFullFlag(almostFullFlag), .halfFullFlag(halfFullFlag), .almostEmptyFlag(almostEmptyFlag),
        .emptyFlag(emptyFlag), .irq(irq));

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", checked, nErrors);
        if (nErrors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Hang guard, far above the roughly 2600 cycles the tests need
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            nErrors++;
            conclude();
        end
    end

    // Request held until the edge that samples pready high; data taken there
    task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d);
        int waits;
        waits = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
        begin
            waits++;
            @(posedge sys_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        `CHK(waits, 0)
    endtask

    task automatic move(input logic w, input int k);
        if (k > 0)
        begin
            @(posedge sys_clk);
            go <= 1'b1;
            dirWr <= w;
            len <= k[11:0];
            @(posedge sys_clk);
            go <= 1'b0;
            @(posedge sys_clk);
            while (busy === 1'b1)
                @(posedge sys_clk);
        end
    endtask

    // Straps held steady well before, during and after master reset
    task automatic mreset(input logic ld, p0, p1, sa, iw, ow);
        @(posedge sys_clk);
        loadSelect <= ld;
        pick0 <= p0;
        pick1 <= p1;
        showAhead <= sa;
        inW <= iw;
        outW <= ow;
        repeat (4) @(posedge sys_clk);
        masterResetN <= 1'b0;
        repeat (5) @(posedge sys_clk);
        masterResetN <= 1'b1;
        repeat (5) @(posedge sys_clk);
        cnt = 0;
    endtask

    // Expected {full, almostFull, halfFull, almostEmpty, empty} pins for c words
    function automatic logic [4:0] expFlags(input int c, n, m, sa);
        int cap;
        int half;
        cap = 512 + sa;
        half = 256 + sa;
        return {(c == cap) ~^ sa[0], !(c >= cap - m), !(c > half), c > n + sa, (c == 0) ~^ sa[0]};
    endfunction

    task automatic goTo(input int c, n, m, sa);
        if (c > cnt)
            move(1'b1, c - cnt);
        else
            move(1'b0, cnt - c);
        cnt = c;
        `CHK({fullFlag, almostFullFlag, halfFullFlag, almostEmptyFlag, emptyFlag}, expFlags(c, n, m, sa))
        apb(`SFD_REG_COUNT, 1'b0, 32'h0);
        `CHK(rd, c)
    endtask

    task automatic sweep(input int sa, n, m);
        int pts[12];
        pts = '{0, 1, n, n + 1, n + 2, 256 + sa, 257 + sa, 258 + sa, 511 + sa - m, 512 + sa - m, 511 + sa, 512 + sa};
        apb(`SFD_REG_EMPTY_OFS, 1'b1, n);
        apb(`SFD_REG_FULL_OFS, 1'b1, m);
        apb(`SFD_REG_IRQ_STAT, 1'b1, 32'hf);
        apb(`SFD_REG_IRQ_MASK, 1'b1, 32'hf);
        for (int i = 0; i < 12; i++)
            goTo(pts[i], n, m, sa);
        move(1'b1, 1);
        goTo(512 + sa, n, m, sa);
        `CHK(irq, 1'b1)
        apb(`SFD_REG_IRQ_STAT, 1'b0, 32'h0);
        `CHK(rd, 32'h5)
        apb(`SFD_REG_IRQ_STAT, 1'b1, 32'h5);
        @(posedge sys_clk);
        `CHK(irq, 1'b0)
        for (int i = 10; i >= 0; i--)
            goTo(pts[i], n, m, sa);
        move(1'b0, 1);
        apb(`SFD_REG_IRQ_STAT, 1'b0, 32'h0);
        `CHK(rd, 32'ha)
        apb(`SFD_REG_IRQ_MASK, 1'b1, 32'h0);
        @(posedge sys_clk);
        `CHK(irq, 1'b0)
        $display("test flag sweep %0d done", sa);
    endtask

    initial
    begin
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            mreset(i[2], i[1], i[0], 1'b0, 1'b1, 1'b1);
            apb(`SFD_REG_EMPTY_OFS, 1'b0, 32'h0);
            `CHK(rd, defs[i])
            apb(`SFD_REG_FULL_OFS, 1'b0, 32'h0);
            `CHK(rd, defs[i])
        end
        apb(`SFD_REG_STATUS, 1'b0, 32'h0);
        `CHK(rd, 32'h47)
        $display("test defaults done");
        apb(`SFD_REG_EMPTY_OFS, 1'b1, 32'h3ff);
        apb(`SFD_REG_EMPTY_OFS, 1'b0, 32'h0);
        `CHK(rd, 32'h1ff)
        mreset(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        apb(`SFD_REG_FULL_OFS, 1'b1, 32'hfffff);
        apb(`SFD_REG_FULL_OFS, 1'b0, 32'h0);
        `CHK(rd, 32'h3ff)
        apb(`SFD_REG_STATUS, 1'b0, 32'h0);
        `CHK(rd, 32'h87)
        apb(32'h18, 1'b0, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        $display("test widths done");
        mreset(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        // Writes offered while frozen must not be counted
        clkEn <= 1'b0;
        move(1'b1, 3);
        clkEn <= 1'b1;
        apb(`SFD_REG_COUNT, 1'b0, 32'h0);
        `CHK(rd, 32'h0)
        sweep(0, 4, 3);
        mreset(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        sweep(1, 9, 20);
        conclude();
    end
endmodule
